/* dv/thb_link_chk.sv */
// Checker for the pin link between the processor end and its outside party.
// Assumes the bench instantiates it beside the link with the bench clock and reset.
`timescale 1ns/1ns
module thb_link_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic hold_request_n,
	input wire logic coprocessor_present_n,
	input wire logic ready,
	input wire logic bootstrap_n,
	input wire logic device_reset_n,
	input wire logic trap_acknowledge,
	input wire logic bus_grant_ack,
	input wire logic wait_flag,
	input wire logic instruction_fetch_strobe,
	input wire logic cycle_end_n,
	input wire logic map_enable_n,
	input wire logic memory_enable_n,
	input wire logic bus_input_phase,
	input wire logic write_enable_n,
	input wire logic bit_io_strobe
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Pins cross a two-flop synchroniser, so the bounds below allow for that lag.
	grant_lines_high_a: assert property (
		bus_grant_ack |-> memory_enable_n && write_enable_n && map_enable_n && cycle_end_n
		&& instruction_fetch_strobe && bus_input_phase) else $error("bus line low in hold");
	grant_cause_a: assert property (
		$rose(bus_grant_ack) |-> !hold_request_n || !coprocessor_present_n)
		else $error("grant without request");
	hold_taken_a: assert property (
		(!hold_request_n && ready && device_reset_n)[*8] |-> ##[0:8] bus_grant_ack)
		else $error("hold request not granted");
	grant_release_a: assert property (
		$rose(hold_request_n) && coprocessor_present_n |-> ##[1:5] !bus_grant_ack)
		else $error("grant kept after release");
	boot_in_hold_a: assert property (
		(bus_grant_ack && !bootstrap_n)[*5] |-> trap_acknowledge)
		else $error("pending bootstrap not shown in hold");
	reset_trap_a: assert property (
		$rose(device_reset_n) |-> ##[2:10] trap_acknowledge)
		else $error("no acknowledge after reset");
	map_in_trap_a: assert property (
		trap_acknowledge && !bus_grant_ack |-> map_enable_n)
		else $error("map enable low in trap");
	reset_quiet_a: assert property (
		(!device_reset_n)[*3] |-> write_enable_n && !bit_io_strobe)
		else $error("strobe active in reset");
	wait_cause_a: assert property (
		$rose(wait_flag) |-> !ready || !$past(ready) || !$past(ready, 2) || !$past(ready, 3))
		else $error("wait without not ready");
	wait_clear_a: assert property (
		ready[*5] |-> !wait_flag) else $error("wait kept while ready");
	cover property ($rose(bus_grant_ack));
	cover property ($rose(wait_flag));
	cover property (bus_grant_ack && trap_acknowledge);
	cover property ($rose(trap_acknowledge));
endmodule // thb_link_chk

/* dv/trap_hold_bus_control_tb_top.sv */
// Bench for the trap, hold and bus control link with both ends facing each other.
// Assumes the design files and the link checker are compiled before it.
`timescale 1ns/1ns
module trap_hold_bus_control_tb_top;
	logic clk_in;
	logic rst_n_in;
	logic [15:0] status;
	logic [8:0] core;
	logic [6:0] hreq;
	logic [3:0] lvl;
	logic stall, take, save, reload, grant, ack, rstq;
	logic [15:0] vec, clr;
	int fails;
	int comparisons;
	thb_link_if link ();
	thb_dev_end thb_dev_end_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link.dev),
		.core_status_in(status), .core_fetch_in(core[0]), .core_mem_cycle_in(core[1]),
		.core_mem_read_in(core[2]), .core_mem_write_in(core[3]), .core_bit_io_in(core[4]),
		.core_insn_end_in(core[5]), .core_idle_in(core[6]), .core_abs_read_in(core[7]),
		.core_undef_op_in(core[8]), .core_stall_out(stall), .trap_take_out(take),
		.trap_vector_out(vec), .trap_status_clear_out(clr), .ctx_save_out(save),
		.ctx_reload_out(reload));
	thb_host_end thb_host_end_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link.host),
		.irq_req_in(hreq[0]), .irq_level_in(lvl), .dma_req_in(hreq[1]), .mem_ready_in(hreq[2]),
		.boot_req_in(hreq[3]), .cop_claim_in(hreq[4]), .cop_done_in(hreq[5]),
		.reset_req_in(hreq[6]), .dma_grant_out(grant), .trap_ack_out(ack), .in_reset_out(rstq));
	thb_link_chk thb_link_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.hold_request_n(link.hold_request_n), .coprocessor_present_n(link.coprocessor_present_n),
		.ready(link.ready), .bootstrap_n(link.bootstrap_n), .device_reset_n(link.device_reset_n),
		.trap_acknowledge(link.trap_acknowledge), .bus_grant_ack(link.bus_grant_ack),
		.wait_flag(link.wait_flag), .instruction_fetch_strobe(link.instruction_fetch_strobe),
		.cycle_end_n(link.cycle_end_n), .map_enable_n(link.map_enable_n),
		.memory_enable_n(link.memory_enable_n), .bus_input_phase(link.bus_input_phase),
		.write_enable_n(link.write_enable_n), .bit_io_strobe(link.bit_io_strobe));
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic put_h(input int b, input logic v);
		@(posedge clk_in);
		hreq[b] <= v;
	endtask
	task automatic put_c(input logic [8:0] v);
		@(posedge clk_in);
		core <= v;
	endtask
	function automatic logic sel(input int k);
		case (k)
			0: sel = take;
			1: sel = ack;
			2: sel = link.bus_grant_ack;
			3: sel = link.wait_flag;
			4: sel = save;
			5: sel = reload;
			6: sel = !link.wait_flag;
			default: sel = !link.bus_grant_ack;
		endcase
	endfunction
	// Polls at falling edges so that registered outputs have settled.
	task automatic wt(input int k);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (sel(k) !== 1'b1 && n < 40);
		chk1(sel(k), 1'b1);
	endtask
	task automatic trap(input logic [15:0] v);
		wt(0);
		chk16(vec, v);
	endtask
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// The tests need well under 1000 cycles; this allows ten thousand.
	initial begin
		#40000;
		fails++;
		finish_test();
	end
	initial begin
		rst_n_in = 1'b0;
		status = 16'h0000;
		core = 9'h026;
		hreq = 7'h04;
		lvl = 4'h5;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		trap(16'h0000);
		chk16(clr, 16'hFFFF);
		wt(1);
		put_h(6, 1'b1);
		put_h(3, 1'b1);
		put_h(6, 1'b0);
		@(negedge clk_in);
		chk1(rstq, 1'b1);
		trap(16'h0000);
		trap(16'hFFFC);
		chk16(clr, 16'h01FF);
		put_h(3, 1'b0);
		@(posedge clk_in);
		status <= 16'h0004;
		put_h(0, 1'b1);
		repeat (20) begin
			@(negedge clk_in);
			chk1(take, 1'b0);
		end
		@(posedge clk_in);
		status <= 16'h0005;
		trap(16'h0014);
		put_h(0, 1'b0);
		@(posedge clk_in);
		status <= 16'h0000;
		lvl <= 4'h0;
		put_h(0, 1'b1);
		trap(16'h0000);
		put_h(0, 1'b0);
		@(posedge clk_in);
		status <= 16'h0080;
		repeat (8) @(negedge clk_in);
		chk1(link.map_enable_n, 1'b0);
		put_h(1, 1'b1);
		wt(2);
		chk1(link.memory_enable_n, 1'b1);
		put_h(3, 1'b1);
		wt(1);
		chk1(grant, 1'b1);
		put_h(1, 1'b0);
		trap(16'hFFFC);
		put_h(3, 1'b0);
		put_h(2, 1'b0);
		wt(3);
		chk1(link.cycle_end_n, 1'b1);
		chk1(stall, 1'b1);
		put_h(2, 1'b1);
		wt(6);
		chk1(link.cycle_end_n, 1'b0);
		put_c(9'h086);
		put_c(9'h006);
		repeat (2) @(negedge clk_in);
		chk1(link.locked_rmw_flag, 1'b1);
		chk1(link.instruction_fetch_strobe, 1'b0);
		put_c(9'h026);
		repeat (3) @(negedge clk_in);
		chk1(link.locked_rmw_flag, 1'b0);
		put_c(9'h01A);
		repeat (2) @(negedge clk_in);
		chk1(link.write_enable_n, 1'b0);
		chk1(link.bit_io_strobe, 1'b1);
		chk1(link.bus_input_phase, 1'b1);
		put_c(9'h127);
		put_h(4, 1'b1);
		@(negedge clk_in);
		chk1(link.instruction_fetch_strobe, 1'b1);
		wt(4);
		chk16(vec, 16'h0008);
		wt(2);
		put_c(9'h026);
		put_h(4, 1'b0);
		put_h(5, 1'b1);
		wt(5);
		put_h(5, 1'b0);
		wt(7);
		put_c(9'h027);
		put_h(4, 1'b1);
		trap(16'h0008);
		put_h(4, 1'b0);
		put_c(9'h026);
		repeat (10) @(posedge clk_in);
		finish_test();
	end
endmodule // trap_hold_bus_control_tb_top

/* verilog/thb_dev_end.sv */
// Processor end: traps, interrupts, bus hold, wait states and cycle flags.
// Assumes a core on the user side that reports its cycles and takes trap orders.
`timescale 1ns/1ns
`include "thb_params.svh"

// What this block does
// RL1: Level code all-low highest, all-high lowest.
// RL2: Latch code; accept when code within mask.
// RL3: Failed compare ignored; code keeps being resampled.
// RL4: Acknowledge high during workspace pointer fetch.
// RL5: In hold, acknowledge shows pending trap.
// RL6: Hold after cycle end; bus lines high.
// RL7: Hold release resumes the suspended instruction.
// RL8: Hold from request or coprocessor on opcode.
// RL9: Ready low makes the device wait.
// RL10: Wait output high during wait state.
// RL11: Fetch strobe high on instruction fetches.
// RL12: Cycle end low before next cycle.
// RL13: Interlock from operand read to instruction end.
// RL14: Hold sampled while interlock high.
// RL15: Coprocessor: save context, then hold.
// RL16: Coprocessor release: regain bus, reload context.
// RL17: Coprocessor during fetch traps to level two.
// RL18: Bootstrap trap after instruction, vectors FFFC.
// RL19: Bootstrap ends idle, follows reset trap.
// RL20: Bootstrap in hold raises acknowledge.
// RL21: Reset pin low resets, suppresses strobes.
// RL22: Reset release runs level-zero trap.
// RL23: Map enable inverts status bit, high in traps.
module thb_dev_end
	import thb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	thb_link_if.dev link,
	input wire logic [15:0] core_status_in,
	input wire logic core_fetch_in,
	input wire logic core_mem_cycle_in,
	input wire logic core_mem_read_in,
	input wire logic core_mem_write_in,
	input wire logic core_bit_io_in,
	input wire logic core_insn_end_in,
	input wire logic core_idle_in,
	input wire logic core_abs_read_in,
	input wire logic core_undef_op_in,
	output logic core_stall_out,
	output logic trap_take_out,
	output logic [15:0] trap_vector_out,
	output logic [15:0] trap_status_clear_out,
	output logic ctx_save_out,
	output logic ctx_reload_out
);
	logic [9:0] pins_s;
	logic int_n_s;
	logic [3:0] code_s;
	logic hold_n_s;
	logic ready_s;
	logic cop_n_s;
	logic boot_n_s;
	logic rst_pin_n_s;
	thb_state_t state_ff;
	thb_state_t nxt_state;
	thb_kind_t kind_ff;
	thb_kind_t nxt_kind;
	logic [`THB_TRAP_CNT_W-1:0] cnt_ff;
	logic [3:0] code_ff;
	logic brk_ff;
	logic xip_hold_ff;
	logic lock_ff;
	logic int_ok;
	logic cyc_done;
	logic start_trap;
	logic [15:0] vec;

	thb_sync #(.W(10)) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in({link.interrupt_request_n, link.interrupt_level_code, link.hold_request_n,
			link.ready, link.coprocessor_present_n, link.bootstrap_n, link.device_reset_n}),
		.q_out(pins_s)
	);
	assign {int_n_s, code_s, hold_n_s, ready_s, cop_n_s, boot_n_s, rst_pin_n_s} = pins_s;

	// A lower code is a higher priority, so acceptance is a plain unsigned compare.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			code_ff <= 4'hF;
		end else if (!int_n_s) begin
			code_ff <= code_s; // RL2 RL3
		end
	end
	assign int_ok = !int_n_s && (code_ff <= core_status_in[`THB_ST_MASK_LSB +: 4]); // RL1 RL2

	assign cyc_done = (state_ff == THB_S_RUN) && !(core_mem_cycle_in && !ready_s); // RL9
	assign start_trap = cyc_done && (((core_insn_end_in || core_idle_in) && (!boot_n_s || int_ok))
		|| (core_insn_end_in && brk_ff));

	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		case (state_ff)
			THB_S_RESET: begin
				if (rst_pin_n_s) begin
					nxt_state = THB_S_TRAP; // RL22
					nxt_kind = THB_K_RESET;
				end
			end
			THB_S_TRAP: begin
				if (cnt_ff == `THB_TRAP_CNT_W'(`THB_TRAP_CYCLES - 1)) begin
					if (kind_ff == THB_K_RESET && !boot_n_s) begin
						nxt_kind = THB_K_BOOT; // RL19
					end else begin
						nxt_state = THB_S_RUN;
					end
				end
			end
			THB_S_RUN: begin
				if (core_mem_cycle_in && !ready_s) begin
					nxt_state = THB_S_WAIT; // RL9
				end else if (start_trap) begin
					nxt_state = THB_S_TRAP;
					if (!boot_n_s) begin
						nxt_kind = THB_K_BOOT; // RL18 RL19
					end else if (int_ok) begin
						nxt_kind = THB_K_INT;
					end else begin
						nxt_kind = THB_K_LEVEL2; // RL17
					end
				end else if (!cop_n_s && core_undef_op_in) begin
					nxt_state = THB_S_XSAVE; // RL8 RL15
				end else if (!hold_n_s) begin
					nxt_state = THB_S_HOLD; // RL6 RL8 RL14
				end
			end
			THB_S_WAIT: begin
				if (ready_s) begin
					nxt_state = THB_S_RUN;
				end
			end
			THB_S_XSAVE: begin
				if (cnt_ff == `THB_TRAP_CNT_W'(`THB_XSAVE_CYCLES - 1)) begin
					nxt_state = THB_S_HOLD; // RL15
				end
			end
			THB_S_HOLD: begin
				if (xip_hold_ff ? cop_n_s : hold_n_s) begin
					nxt_state = THB_S_RUN; // RL7 RL16
				end
			end
			default: begin
				nxt_state = THB_S_RESET;
			end
		endcase
		if (!rst_pin_n_s) begin
			nxt_state = THB_S_RESET; // RL21
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= THB_S_RESET;
			kind_ff <= THB_K_RESET;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
		end
	end

	// The counter restarts whenever a sequence starts, including a bootstrap chained after reset.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= '0;
		end else if (nxt_state != state_ff || nxt_kind != kind_ff) begin
			cnt_ff <= '0;
		end else if (state_ff == THB_S_TRAP || state_ff == THB_S_XSAVE) begin
			cnt_ff <= cnt_ff + `THB_TRAP_CNT_W'(1);
		end
	end

	// A breakpoint seen on the fetch strobe is held until the instruction ends or the device leaves the run state.
	// A fetch in the cycle that ends the previous instruction must not be lost, so set wins.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			brk_ff <= 1'b0;
		end else if (state_ff == THB_S_RUN && core_fetch_in && !cop_n_s) begin
			brk_ff <= 1'b1; // RL17
		end else if (state_ff != THB_S_RUN || (cyc_done && core_insn_end_in)) begin
			brk_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xip_hold_ff <= 1'b0;
		end else if (state_ff == THB_S_XSAVE) begin
			xip_hold_ff <= 1'b1; // RL15
		end else if (state_ff != THB_S_HOLD) begin
			xip_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lock_ff <= 1'b0;
		end else if (state_ff == THB_S_RESET || (cyc_done && core_insn_end_in)) begin
			lock_ff <= 1'b0; // RL13
		end else if (cyc_done && core_abs_read_in) begin
			lock_ff <= 1'b1; // RL13
		end
	end

	always_comb begin
		case (kind_ff)
			THB_K_RESET: vec = `THB_VEC_RESET; // RL22
			THB_K_BOOT: vec = `THB_VEC_BOOT; // RL18
			THB_K_INT: vec = {10'h000, code_ff, 2'h0}; // RL2
			default: vec = `THB_VEC_LEVEL2; // RL17
		endcase
	end

	// Trap orders to the core; the sequence completes at the last trap cycle.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trap_take_out <= 1'b0;
			trap_vector_out <= `THB_VEC_RESET;
			trap_status_clear_out <= `THB_CLR_NONE;
			ctx_save_out <= 1'b0;
			ctx_reload_out <= 1'b0;
		end else begin
			trap_take_out <= (state_ff == THB_S_TRAP) && (cnt_ff == `THB_TRAP_CNT_W'(0));
			trap_vector_out <= (state_ff == THB_S_XSAVE) ? `THB_VEC_LEVEL2 : vec; // RL15
			trap_status_clear_out <= (kind_ff == THB_K_RESET) ? `THB_CLR_RESET : // RL22
				(kind_ff == THB_K_BOOT) ? `THB_CLR_BOOT : `THB_CLR_NONE; // RL18
			ctx_save_out <= ((state_ff == THB_S_TRAP) || (state_ff == THB_S_XSAVE))
				&& (cnt_ff == `THB_TRAP_CNT_W'(0));
			ctx_reload_out <= (state_ff == THB_S_HOLD) && xip_hold_ff && cop_n_s; // RL16
		end
	end

	// Pin outputs: hold releases the bus lines high, reset suppresses both write strobes.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.trap_acknowledge <= 1'b0;
			link.bus_grant_ack <= 1'b0;
			link.map_enable_n <= 1'b1;
			link.memory_enable_n <= 1'b1;
			link.bus_input_phase <= 1'b0;
			link.write_enable_n <= 1'b1;
			link.bit_io_strobe <= 1'b0;
			link.locked_rmw_flag <= 1'b0;
			link.instruction_fetch_strobe <= 1'b0;
		end else begin
			if (nxt_state == THB_S_HOLD) begin
				link.trap_acknowledge <= int_ok || !boot_n_s; // RL5 RL20
			end else begin
				link.trap_acknowledge <= (nxt_state == THB_S_TRAP) &&
					(cnt_ff == `THB_TRAP_CNT_W'(`THB_TRAP_WP_FETCH - 1)); // RL4
			end
			link.bus_grant_ack <= (nxt_state == THB_S_HOLD); // RL6 RL8
			link.map_enable_n <= (nxt_state == THB_S_HOLD) || (nxt_state == THB_S_TRAP) ||
				!core_status_in[`THB_ST_MAP_BIT]; // RL23 RL18 RL22
			link.memory_enable_n <= (nxt_state == THB_S_HOLD) || !core_mem_cycle_in; // RL6
			link.bus_input_phase <= (nxt_state == THB_S_HOLD) ||
				(core_mem_read_in || core_bit_io_in) && (nxt_state != THB_S_RESET); // RL6
			link.write_enable_n <= (nxt_state == THB_S_HOLD) || (nxt_state == THB_S_RESET) ||
				!core_mem_write_in; // RL21
			link.bit_io_strobe <= core_bit_io_in && (nxt_state == THB_S_RUN); // RL21
			link.locked_rmw_flag <= lock_ff; // RL13 RL14
			link.instruction_fetch_strobe <= (nxt_state == THB_S_HOLD) ||
				(core_fetch_in && nxt_state == THB_S_RUN); // RL11 RL6
		end
	end

	assign link.wait_flag = (state_ff == THB_S_WAIT); // RL10
	assign link.cycle_end_n = !cyc_done && (state_ff != THB_S_HOLD) ? 1'b1 :
		(state_ff == THB_S_HOLD) ? 1'b1 : 1'b0; // RL12 RL6
	assign core_stall_out = !cyc_done; // RL9
endmodule // thb_dev_end

/* verilog/thb_host_end.sv */
// Outside party: interrupt requester, hold master, coprocessor, memory ready and reset driver.
// Assumes user requests are levels on the same clock as the device end.
`timescale 1ns/1ns
`include "thb_params.svh"
module thb_host_end
	import thb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	thb_link_if.host link,
	input wire logic irq_req_in,
	input wire logic [3:0] irq_level_in,
	input wire logic dma_req_in,
	input wire logic mem_ready_in,
	input wire logic boot_req_in,
	input wire logic cop_claim_in,
	input wire logic cop_done_in,
	input wire logic reset_req_in,
	output logic dma_grant_out,
	output logic trap_ack_out,
	output logic in_reset_out
);
	logic hold_req_ff;
	logic cop_ff;
	logic boot_ff;
	logic [`THB_RESET_CNT_W-1:0] rst_cnt_ff;

	// A request is kept until the user drops it, so a masked level is retried later.
	assign link.interrupt_request_n = !irq_req_in; // RL3
	assign link.interrupt_level_code = irq_level_in; // RL1
	assign link.ready = mem_ready_in; // RL9

	// A new hold is not raised inside a locked read-modify-write.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hold_req_ff <= 1'b0;
		end else if (!dma_req_in) begin
			hold_req_ff <= 1'b0;
		end else if (!link.locked_rmw_flag) begin
			hold_req_ff <= 1'b1; // RL14
		end
	end
	assign link.hold_request_n = !hold_req_ff;

	// Claim an undefined opcode seen on a fetch; release once the work is done.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cop_ff <= 1'b0;
		end else if (cop_ff && cop_done_in && link.bus_grant_ack) begin
			cop_ff <= 1'b0; // RL16
		end else if (cop_claim_in && link.instruction_fetch_strobe) begin
			cop_ff <= 1'b1; // RL15
		end
	end
	assign link.coprocessor_present_n = !cop_ff;

	// The bootstrap request is not dropped while the device sits in hold.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_ff <= 1'b0;
		end else if (boot_req_in) begin
			boot_ff <= 1'b1;
		end else if (!link.bus_grant_ack) begin
			boot_ff <= 1'b0; // RL20
		end
	end
	assign link.bootstrap_n = !boot_ff;

	// Reset pin is held low for at least the least time even for a one-cycle request.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_cnt_ff <= `THB_RESET_CNT_W'(`THB_RESET_MIN_CYC);
		end else if (reset_req_in) begin
			rst_cnt_ff <= `THB_RESET_CNT_W'(`THB_RESET_MIN_CYC); // RL21
		end else if (rst_cnt_ff != '0) begin
			rst_cnt_ff <= rst_cnt_ff - `THB_RESET_CNT_W'(1);
		end
	end
	assign link.device_reset_n = (rst_cnt_ff == '0);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dma_grant_out <= 1'b0;
			trap_ack_out <= 1'b0;
			in_reset_out <= 1'b1;
		end else begin
			dma_grant_out <= hold_req_ff && link.bus_grant_ack;
			trap_ack_out <= link.trap_acknowledge;
			in_reset_out <= (rst_cnt_ff != '0);
		end
	end
endmodule // thb_host_end

/* verilog/thb_link_if.sv */
// Pin-level link between the processor control end and its outside party.
// Assumes both ends run on the same clock; bus lines released in hold read as high.
`timescale 1ns/1ns
interface thb_link_if;
	logic interrupt_request_n;
	logic [3:0] interrupt_level_code;
	logic trap_acknowledge;
	logic hold_request_n;
	logic bus_grant_ack;
	logic ready;
	logic wait_flag;
	logic instruction_fetch_strobe;
	logic cycle_end_n;
	logic locked_rmw_flag;
	logic coprocessor_present_n;
	logic bootstrap_n;
	logic device_reset_n;
	logic map_enable_n;
	logic memory_enable_n;
	logic bus_input_phase;
	logic write_enable_n;
	logic bit_io_strobe;
	modport dev (
		input interrupt_request_n, interrupt_level_code, hold_request_n, ready,
		input coprocessor_present_n, bootstrap_n, device_reset_n,
		output trap_acknowledge, bus_grant_ack, wait_flag, instruction_fetch_strobe,
		output cycle_end_n, locked_rmw_flag, map_enable_n, memory_enable_n,
		output bus_input_phase, write_enable_n, bit_io_strobe
	);
	modport host (
		output interrupt_request_n, interrupt_level_code, hold_request_n, ready,
		output coprocessor_present_n, bootstrap_n, device_reset_n,
		input trap_acknowledge, bus_grant_ack, wait_flag, instruction_fetch_strobe,
		input cycle_end_n, locked_rmw_flag, map_enable_n, memory_enable_n,
		input bus_input_phase, write_enable_n, bit_io_strobe
	);
endinterface

/* verilog/thb_params.svh */
// Constants for the trap, hold and bus control block: vectors, status bit positions, timing.
// Assumes a 16-bit status word numbered with bit 0 as the most significant bit.
`ifndef THB_PARAMS_SVH
`define THB_PARAMS_SVH

`define THB_CLK_PERIOD_NS 4
`define THB_CODE_W 4
`define THB_WORD_W 16
// Status word bit positions in port order (port bit 15 is status bit 0).
`define THB_ST_MASK_LSB 0
`define THB_ST_MAP_BIT 7
// Trap sequence: three context saves, then the new workspace pointer and counter fetch.
`define THB_TRAP_CYCLES 5
`define THB_TRAP_WP_FETCH 3
`define THB_XSAVE_CYCLES 3
`define THB_TRAP_CNT_W 3
`define THB_VEC_RESET 16'h0000
`define THB_VEC_BOOT 16'hFFFC
`define THB_VEC_LEVEL2 16'h0008
`define THB_LEVEL_SHIFT 2
// Reset clears every status bit; bootstrap clears status bits 7-15.
`define THB_CLR_RESET 16'hFFFF
`define THB_CLR_BOOT 16'h01FF
`define THB_CLR_NONE 16'h0000
// Least time the host holds the reset pin low, and its cycle count rounded up.
`define THB_RESET_MIN_NS 8
`define THB_RESET_MIN_CYC ((`THB_RESET_MIN_NS + `THB_CLK_PERIOD_NS - 1) / `THB_CLK_PERIOD_NS)
`define THB_RESET_CNT_W 4

`endif

/* verilog/thb_pkg.sv */
// Types shared by both ends of the trap, hold and bus control link.
// Assumes thb_params.svh for all numeric constants.
package thb_pkg;
	typedef enum logic [2:0] {
		THB_S_RESET = 3'h0,
		THB_S_TRAP = 3'h1,
		THB_S_RUN = 3'h2,
		THB_S_WAIT = 3'h3,
		THB_S_XSAVE = 3'h4,
		THB_S_HOLD = 3'h5
	} thb_state_t;
	typedef enum logic [1:0] {
		THB_K_RESET = 2'h0,
		THB_K_BOOT = 2'h1,
		THB_K_INT = 2'h2,
		THB_K_LEVEL2 = 2'h3
	} thb_kind_t;
endpackage

/* verilog/thb_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs idle high; the first stage is read only by the second.
`timescale 1ns/1ns
module thb_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule // thb_sync
